// *** srb_pkg.sv ***
// shared constants and state types for the bus sequencer
// assumes a single 100 MHz pclk; one sequencer state per pclk (half bus clock)
//
// Summary of operation
// - a read-modify-write runs indivisibly and never uses bursts
// - S0 of read: cycle start, operand start (first read only), lock; address, code, size, read
// - S1: address and data strobes on, cycle start indicators off
// - sample termination at S2, wait states until seen, latch data at S3
// - buffer enable is active from S2 of a read
// - S3 drops strobes; repeat S0-S3 per read; hold address for write part
// - idle states assert nothing new, stay read, data bus not driven
// - S5: address strobe and buffer enable asserted
// - write data in S6; wait states add data strobe; none at zero wait
// - S7 drops strobes, holds address and data; repeat per extra write
// - burst request on cachable read with enable set and miss or empty line
// - no burst request on first part of a line-crossing misaligned access
// - no burst request if cache off, frozen, or in read-modify-write
// - bursts need acknowledge; strobes and address held during the burst
// - latch a long word on each termination until four or abort
// - burst starts with request and acknowledge; request drops after third word
// - abort burst on cache inhibit, bus error, or early acknowledge loss
// - a burst counts as one cycle for halt and bus grant
// - bus error with halt during words two to four aborts, then halts
// - cache inhibit is latched at each recognized read termination; acknowledge is only sampled there
package srb_pkg;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CMD = 8'h04;
   localparam logic [7:0] A_ADDR = 8'h08;
   localparam logic [7:0] A_WDATA = 8'h0C;
   localparam logic [7:0] A_STAT = 8'h10;
   localparam logic [7:0] A_RDATA = 8'h14;
   localparam logic [3:0] A_LINE_HI = 4'h2;
   localparam int CTRL_W = 6;
   localparam int CT_DBE = 0, CT_IBE = 1, CT_DEN = 2;
   localparam int CT_IEN = 3, CT_DFZ = 4, CT_IFZ = 5;
   localparam int CMD_W = 15;
   localparam int C_RMW = 0, C_INS = 1, C_CI = 2, C_MISS = 3;
   localparam int C_INV = 4, C_XLINE = 5, C_RD = 6, C_WR = 8;
   localparam int C_FC = 10, C_SIZ = 13;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
   localparam logic [1:0] LAST_WORD = 2'h3;
   localparam logic [1:0] THIRD_WORD = 2'h2;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0, ST_RD0 = 4'h1, ST_RD1 = 4'h2, ST_RD2 = 4'h3,
      ST_RDW = 4'h4, ST_RD3 = 4'h5, ST_IDL0 = 4'h6, ST_IDL1 = 4'h7,
      ST_WR4 = 4'h8, ST_WR5 = 4'h9, ST_WR6 = 4'hA, ST_WRW = 4'hB,
      ST_WR7 = 4'hC, ST_BRS = 4'hD, ST_BRW = 4'hE, ST_HALT = 4'hF
   } srb_st_e;
   typedef struct packed {
      srb_st_e st;
      logic [CTRL_W-1:0] ctrl;
      logic [CMD_W-1:0] cmd;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic [3:0][31:0] line;
      logic [1:0] cnt;
      logic [1:0] rd_left;
      logic [1:0] wr_left;
      logic breq;
      logic first;
      logic ds_w;
      logic cio;
      logic busreq;
      logic f_bus_error_in;
      logic f_unc;
      logic f_babort;
      logic f_rej;
   } srb_state_s;
endpackage

// *** srb_bus_seq.sv ***
// synchronous read-modify-write and burst fill bus sequencer, apb slave
// assumes synchronous inputs; each state is one pclk, i.e. half a bus clock
`timescale 1ns/100ps
module srb_bus_seq (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // external bus outputs
   output logic [31:0] address,
   output logic [2:0] function_code,
   output logic [1:0] transfer_size,
   output logic read_not_write,
   output logic external_cycle_start,
   output logic operand_cycle_start,
   output logic locked_cycle_indicator,
   output logic address_strobe,
   output logic data_strobe,
   output logic data_buffer_enable,
   output logic cache_inhibit_out,
   output logic burst_request,
   output logic bus_clk_phase,
   output logic [31:0] data_o,
   output logic data_oe,
   // external bus inputs
   input wire logic [31:0] data_i,
   input wire logic sync_termination,
   input wire logic cache_inhibit_in,
   input wire logic burst_acknowledge,
   input wire logic bus_error_in,
   input wire logic halt_in,
   input wire logic bus_request,
   // arbitration and halt status
   output logic bus_grant,
   output logic halted
);
   import srb_pkg::*;

   srb_state_s s_q;
   srb_state_s s_d;
   logic acc;
   logic wr;
   logic can_start;
   logic [1:0] idx;
   logic in_rd_as;
   logic in_wr;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic burst_ok(input logic [CMD_W-1:0] c,
                                     input logic [CTRL_W-1:0] k);
      logic ins;
      logic be;
      logic en;
      logic fz;
      ins = c[C_INS];
      be = ins ? k[CT_IBE] : k[CT_DBE];
      en = ins ? k[CT_IEN] : k[CT_DEN];
      fz = ins ? k[CT_IFZ] : k[CT_DFZ];
      // cachable read that misses or finds an empty line
      burst_ok = be & (c[C_MISS] | c[C_INV]) & !c[C_CI];
      burst_ok = burst_ok & !c[C_XLINE];
      burst_ok = burst_ok & en & !fz & !c[C_RMW];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   // a burst is one cycle: grant or halt only between operations
   assign can_start = (s_q.st == ST_IDLE) & !s_q.busreq & !halt_in;
   // entry written is the starting long word plus words already taken
   assign idx = s_q.addr[3:2] + s_q.cnt;

   always_comb begin
      s_d = s_q;
      s_d.busreq = bus_request;
      if (wr && s_q.st == ST_IDLE) begin
         if (paddr == A_CTRL) begin
            s_d.ctrl = pwdata[CTRL_W-1:0];
         end
         if (paddr == A_ADDR) begin
            s_d.addr = pwdata;
         end
         if (paddr == A_WDATA) begin
            s_d.wdata = pwdata;
         end
      end
      unique case (s_q.st)
         ST_IDLE: begin
            if (halt_in) begin
               s_d.st = ST_HALT;
            end
         end
         ST_HALT: begin
            if (!halt_in) begin
               s_d.st = ST_IDLE;
            end
         end
         ST_RD0: begin
            s_d.st = ST_RD1;
         end
         ST_RD1: begin
            s_d.st = ST_RD2;
         end
         ST_RD2: begin
            if (bus_error_in) begin
               s_d.f_bus_error_in = 1'b1;
               s_d.breq = 1'b0;
               s_d.st = ST_RD3;
            end else if (sync_termination) begin
               // capture lands on the falling half that opens S3
               s_d.rdata = data_i;
               s_d.line[idx] = data_i;
               s_d.cnt = s_q.cnt + 2'h1;
               s_d.f_unc = s_q.f_unc | cache_inhibit_in;
               if (s_q.breq && burst_acknowledge && !cache_inhibit_in &&
                   !s_q.cmd[C_RMW]) begin
                  s_d.st = ST_BRW;
               end else begin
                  s_d.breq = 1'b0;
                  s_d.st = ST_RD3;
               end
            end else begin
               s_d.st = ST_RDW;
            end
         end
         ST_RDW: begin
            s_d.st = ST_RD2;
         end
         ST_RD3: begin
            s_d.breq = 1'b0;
            s_d.first = 1'b0;
            if (s_q.f_bus_error_in) begin
               s_d.st = ST_IDLE;
            end else if (s_q.rd_left != 2'h0) begin
               s_d.rd_left = s_q.rd_left - 2'h1;
               s_d.st = ST_RD0;
            end else if (s_q.cmd[C_RMW]) begin
               s_d.first = 1'b1;
               s_d.st = ST_IDL0;
            end else begin
               s_d.st = ST_IDLE;
            end
         end
         ST_IDL0: begin
            s_d.st = ST_IDL1;
         end
         ST_IDL1: begin
            s_d.st = ST_WR4;
         end
         ST_WR4: begin
            s_d.cio = s_q.cmd[C_CI];
            s_d.st = ST_WR5;
         end
         ST_WR5: begin
            s_d.st = ST_WR6;
         end
         ST_WR6: begin
            if (bus_error_in) begin
               s_d.f_bus_error_in = 1'b1;
               s_d.ds_w = 1'b0;
               s_d.st = ST_WR7;
            end else if (sync_termination) begin
               s_d.ds_w = 1'b0;
               s_d.st = ST_WR7;
            end else begin
               // only a stretched write shows the data strobe
               s_d.ds_w = 1'b1;
               s_d.st = ST_WRW;
            end
         end
         ST_WRW: begin
            s_d.st = ST_WR6;
         end
         ST_WR7: begin
            s_d.first = 1'b0;
            if (!s_q.f_bus_error_in && s_q.wr_left != 2'h0) begin
               s_d.wr_left = s_q.wr_left - 2'h1;
               s_d.st = ST_WR4;
            end else begin
               s_d.st = ST_IDLE;
            end
         end
         ST_BRW: begin
            s_d.st = ST_BRS;
         end
         ST_BRS: begin
            if (bus_error_in) begin
               // with halt too this is an error, not a retry
               s_d.f_bus_error_in = 1'b1;
               s_d.f_babort = 1'b1;
               s_d.breq = 1'b0;
               s_d.st = ST_RD3;
            end else if (sync_termination) begin
               s_d.rdata = data_i;
               s_d.line[idx] = data_i;
               s_d.cnt = s_q.cnt + 2'h1;
               s_d.f_unc = s_q.f_unc | cache_inhibit_in;
               if (s_q.cnt == THIRD_WORD) begin
                  s_d.breq = 1'b0;
               end
               if (s_q.cnt == LAST_WORD) begin
                  s_d.st = ST_RD3;
               end else if (cache_inhibit_in || !burst_acknowledge) begin
                  s_d.f_babort = 1'b1;
                  s_d.breq = 1'b0;
                  s_d.st = ST_RD3;
               end else begin
                  s_d.st = ST_BRW;
               end
            end else begin
               s_d.st = ST_BRW;
            end
         end
      endcase
      if (wr && paddr == A_CMD) begin
         if (can_start) begin
            s_d.cmd = pwdata[CMD_W-1:0];
            s_d.rd_left = pwdata[C_RD+1:C_RD];
            s_d.wr_left = pwdata[C_WR+1:C_WR];
            s_d.cio = pwdata[C_CI];
            s_d.breq = burst_ok(pwdata[CMD_W-1:0], s_q.ctrl);
            s_d.cnt = 2'h0;
            s_d.first = 1'b1;
            s_d.ds_w = 1'b0;
            s_d.f_bus_error_in = 1'b0;
            s_d.f_unc = 1'b0;
            s_d.f_babort = 1'b0;
            s_d.f_rej = 1'b0;
            s_d.st = ST_RD0;
         end else begin
            s_d.f_rej = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus pins decoded from state
   assign in_rd_as = (s_q.st == ST_RD1) | (s_q.st == ST_RD2) |
                     (s_q.st == ST_RDW) | (s_q.st == ST_BRS) |
                     (s_q.st == ST_BRW);
   assign in_wr = (s_q.st == ST_WR4) | (s_q.st == ST_WR5) |
                  (s_q.st == ST_WR6) | (s_q.st == ST_WRW) |
                  (s_q.st == ST_WR7);
   assign address = s_q.addr;
   assign function_code = s_q.cmd[C_FC+2:C_FC];
   assign transfer_size = s_q.cmd[C_SIZ+1:C_SIZ];
   assign read_not_write = !in_wr;
   assign external_cycle_start = (s_q.st == ST_RD0) |
                                 (s_q.st == ST_WR4);
   assign operand_cycle_start = external_cycle_start & s_q.first;
   assign locked_cycle_indicator = s_q.cmd[C_RMW] &
                                   (s_q.st != ST_IDLE) &
                                   (s_q.st != ST_HALT);
   assign address_strobe = in_rd_as | (s_q.st == ST_WR5) |
                           (s_q.st == ST_WR6) | (s_q.st == ST_WRW);
   assign data_strobe = in_rd_as | s_q.ds_w;
   assign data_buffer_enable = (in_rd_as & (s_q.st != ST_RD1)) |
                               (in_wr & (s_q.st != ST_WR4));
   assign cache_inhibit_out = s_q.cio;
   assign burst_request = s_q.breq & in_rd_as;
   // bus clock high during the rising-edge states
   assign bus_clk_phase = (s_q.st == ST_RD0) | (s_q.st == ST_RD2) |
                          (s_q.st == ST_IDL0) | (s_q.st == ST_WR4) |
                          (s_q.st == ST_WR6) | (s_q.st == ST_BRS);
   assign data_o = s_q.wdata;
   // data bus left alone until S6 so the read cannot collide
   assign data_oe = (s_q.st == ST_WR6) | (s_q.st == ST_WRW) |
                    (s_q.st == ST_WR7);
   assign bus_grant = (s_q.st == ST_IDLE) & s_q.busreq;
   assign halted = (s_q.st == ST_HALT);

   ////////////////////////////////////////////////////////////////////////
   // apb read side, zero wait states
   assign pready = 1'b1;

   always_comb begin
      prdata = 32'h00000000;
      pslverr = 1'b0;
      if (paddr[7:4] == A_LINE_HI && paddr[1:0] == 2'h0) begin
         prdata = s_q.line[paddr[3:2]];
      end else begin
         unique case (paddr)
            A_CTRL: prdata = 32'(s_q.ctrl);
            A_CMD: prdata = 32'(s_q.cmd);
            A_ADDR: prdata = s_q.addr;
            A_WDATA: prdata = s_q.wdata;
            A_RDATA: prdata = s_q.rdata;
            A_STAT: prdata = {23'h000000, bus_grant, s_q.cnt, s_q.f_rej,
                              s_q.f_babort, s_q.f_unc, s_q.f_bus_error_in,
                              halted, (s_q.st != ST_IDLE) & !halted};
            default: pslverr = acc;
         endcase
      end
   end
endmodule

// *** srb_monitor.sv ***
// timing checks on the external bus pins of the sequencer
// assumes one pclk domain; bound into the design by port name
`timescale 1ns/100ps
module srb_monitor (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bus outputs
   input wire logic [31:0] address,
   input wire logic [2:0] function_code,
   input wire logic [1:0] transfer_size,
   input wire logic read_not_write,
   input wire logic external_cycle_start,
   input wire logic operand_cycle_start,
   input wire logic locked_cycle_indicator,
   input wire logic address_strobe,
   input wire logic data_strobe,
   input wire logic data_buffer_enable,
   input wire logic burst_request,
   input wire logic bus_clk_phase,
   input wire logic [31:0] data_o,
   input wire logic data_oe,
   input wire logic bus_grant,
   // bus inputs
   input wire logic sync_termination,
   input wire logic cache_inhibit_in,
   input wire logic burst_acknowledge,
   input wire logic bus_error_in
);
   logic [1:0] tcnt_q;
   logic go;
   assign go = burst_request & burst_acknowledge & !cache_inhibit_in;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // terminations seen while the strobe stays up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tcnt_q <= 2'h0;
      else if (!address_strobe) tcnt_q <= 2'h0;
      else if (sync_termination && bus_clk_phase) tcnt_q <= tcnt_q + 2'h1;
   end
   sequence s_samp;
      address_strobe && bus_clk_phase && !bus_error_in;
   endsequence
   sequence s_term;
      s_samp ##0 sync_termination;
   endsequence
   AST_START: assert property (external_cycle_start |=> address_strobe &&
      !external_cycle_start && !operand_cycle_start) else $error("start");
   AST_LOCK0: assert property ($rose(locked_cycle_indicator) |->
      external_cycle_start && operand_cycle_start && read_not_write &&
      !data_buffer_enable) else $error("rmw s0");
   AST_WAIT: assert property (s_samp ##0 !sync_termination |=>
      address_strobe) else $error("wait state");
   AST_DATA_BUFFER_ENABLE: assert property (s_samp ##0 read_not_write |->
      data_buffer_enable) else $error("buffer enable");
   AST_END: assert property (s_term ##0 read_not_write && !go |=>
      !address_strobe && !data_strobe && !data_buffer_enable)
      else $error("read end");
   AST_BURST: assert property (s_term ##0 read_not_write && go |=>
      address_strobe && data_strobe) else $error("burst held");
   AST_BREQ3: assert property (address_strobe && tcnt_q == 2'h3 |->
      !burst_request) else $error("request after third");
   AST_HOLD: assert property (address_strobe && $past(address_strobe) |->
      $stable(address) && $stable(function_code) &&
      $stable(transfer_size) && $stable(read_not_write))
      else $error("held fields");
   AST_OE: assert property (data_oe |-> !read_not_write)
      else $error("early drive");
   AST_ZW: assert property ($rose(data_oe) |=>
      data_strobe == !$past(sync_termination)) else $error("write strobe");
   AST_S7: assert property (data_oe && bus_clk_phase && sync_termination
      |=> !address_strobe && !data_strobe && data_oe && $stable(data_o)
      && $stable(address)) else $error("s7 hold");
   AST_LOCK: assert property (locked_cycle_indicator |-> !burst_request)
      else $error("burst in rmw");
   AST_GRANT: assert property (bus_grant |-> !address_strobe &&
      !locked_cycle_indicator) else $error("grant in cycle");
endmodule

// *** srb_mem_model.sv ***
// synchronous memory answering the sequencer's bus
// assumes bench knobs: wait count, acknowledged words, faults after word 0
`timescale 1ns/100ps
module srb_mem_model (
   // bus side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic address_strobe,
   input wire logic bus_clk_phase,
   input wire logic read_not_write,
   input wire logic [31:0] address,
   input wire logic [31:0] data_o,
   output logic [31:0] data_i,
   output logic sync_termination,
   output logic cache_inhibit_in,
   output logic burst_acknowledge,
   output logic bus_error_in,
   // bench knobs and capture
   input wire logic [1:0] waits,
   input wire logic [2:0] ack_words,
   input wire logic cii_on,
   input wire logic bus_error_in_on,
   output logic [31:0] wseen
);
   logic [1:0] cnt_q;
   logic [2:0] k_q;
   logic [1:0] idx;
   logic [31:0] last_q;
   logic late;
   assign late = k_q != 3'h0;
   assign idx = address[3:2] + k_q[1:0];
   // termination only in a sample half, dropped the next half
   assign sync_termination = address_strobe & bus_clk_phase
      & (cnt_q == waits);
   assign burst_acknowledge = sync_termination & (k_q < ack_words);
   assign cache_inhibit_in = sync_termination & cii_on & late;
   assign bus_error_in = sync_termination & bus_error_in_on & late;
   // released bus shows the inverse of the last word, never a stale copy
   assign data_i = (sync_termination & read_not_write) ?
      (32'hC0DE0000 | {30'h0, idx}) : ~last_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 2'h0;
         k_q <= 3'h0;
         last_q <= 32'h0;
         wseen <= 32'h0;
      end else begin
         if (!address_strobe) begin
            cnt_q <= 2'h0;
            k_q <= 3'h0;
         end else if (sync_termination) begin
            cnt_q <= 2'h0;
            k_q <= k_q + 3'h1;
         end else if (bus_clk_phase) cnt_q <= cnt_q + 2'h1;
         if (sync_termination) last_q <= data_i;
         if (sync_termination & !read_not_write) wseen <= data_o;
      end
   end
endmodule

// *** srb_bus_seq_bench.sv ***
// bench for the sequencer: apb tasks, memory model, scenario tasks
// assumes apb answers in the first access cycle and ports connect by name
`timescale 1ns/100ps
module srb_bus_seq_bench;
   import srb_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, address, data_o, data_i, wseen, rv;
   logic [2:0] function_code, ack_words;
   logic [1:0] transfer_size, waits;
   logic read_not_write, external_cycle_start, operand_cycle_start;
   logic locked_cycle_indicator, address_strobe, data_strobe, data_oe;
   logic data_buffer_enable, cache_inhibit_out, burst_request;
   logic bus_clk_phase, sync_termination, cache_inhibit_in, bus_grant;
   logic burst_acknowledge, bus_error_in, halt_in, bus_request;
   logic halted, cii_on, bus_error_in_on, saw_br;
   int n_fail, num_checks;
   srb_bus_seq u_srb_bus_seq (.*);
   srb_mem_model u_srb_mem_model (.*);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) if (burst_request === 1'b1) saw_br <= 1'b1;
   // halt must join the error inside the burst, else the command is refused
   always @(posedge pclk) if (bus_error_in_on && burst_request === 1'b1) halt_in <= 1'b1;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic run(input logic [31:0] c, input logic [31:0] a,
                      input logic [31:0] m);
      xfer(1'b1, A_CTRL, c);
      xfer(1'b1, A_ADDR, a);
      xfer(1'b1, A_WDATA, 32'h5EED0000 | a);
      saw_br = 1'b0;
      xfer(1'b1, A_CMD, m);
      for (int i = 0; i < 40; i++) begin
         xfer(1'b0, A_STAT, 32'h0);
         if (rv[0] === 1'b0) break;
      end
      chk(32'(rv[0]), 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // read-modify-write with zero and one write waits, extra write
   task automatic t_rmw;
      for (int w = 0; w < 2; w++) begin
         waits <= 2'(w);
         run(32'h5, 32'h208, 32'h10B | (32'h1 << C_WR));
         chk(wseen, 32'h5EED0208);
         chk(32'(saw_br), 32'h0);
         xfer(1'b0, A_RDATA, 32'h0);
         chk(rv, 32'hC0DE0002);
      end
   endtask
   // no-miss, cache off, frozen, line-crossing and inhibit cases that must withhold the burst request
   task automatic t_nobr;
      logic [31:0] tc[5] = '{32'h5, 32'h1, 32'h15, 32'h5, 32'h5};
      logic [31:0] tm[5] = '{32'h0, 32'h8, 32'h8, 32'h28, 32'hC};
      waits <= 2'h0;
      for (int i = 0; i < 5; i++) begin
         run(tc[i], 32'h104, tm[i]);
         chk(32'(saw_br), 32'h0);
         chk(32'(cache_inhibit_out), 32'(tm[i][C_CI]));
      end
   endtask
   // full bursts into data and instruction line from word one
   task automatic t_burst;
      ack_words <= 3'h4;
      for (int j = 0; j < 2; j++) begin
         waits <= 2'(j);
         run(j ? 32'hA : 32'h5, 32'h104, j ? 32'h12 : 32'h8);
         chk(32'(saw_br), 32'h1);
         for (int i = 0; i < 4; i++) begin
            xfer(1'b0, {A_LINE_HI, 2'(i), 2'b00}, 32'h0);
            chk(rv, 32'hC0DE0000 | i);
         end
      end
   endtask
   // early ack loss, inhibit in word two, error with halt in word two
   task automatic t_abort;
      logic [31:0] mk[3] = '{32'h1C, 32'h1C, 32'h04};
      logic [31:0] ex[3] = '{32'h10, 32'h18, 32'h04};
      for (int i = 0; i < 3; i++) begin
         ack_words <= i ? 3'h4 : 3'h2;
         cii_on <= i == 1;
         bus_error_in_on <= i == 2;
         run(32'h5, 32'h100, 32'h8);
         chk(rv & mk[i], ex[i]);
      end
      chk(32'(halted), 32'h1);
      halt_in <= 1'b0;
      bus_error_in_on <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(32'(halted), 32'h0);
   endtask
   // command during a cycle, unmapped place, bus grant when idle
   task automatic t_misc;
      waits <= 2'h3;
      // four slow reads keep the sequencer busy past the next command
      xfer(1'b1, A_CMD, 32'hC0);
      run(32'h0, 32'h0, 32'h0);
      chk(rv & 32'h20, 32'h20);
      xfer(1'b0, 8'h40, 32'h0);
      chk(32'(perr), 32'h1);
      bus_request <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(32'(bus_grant), 32'h1);
      bus_request <= 1'b0;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, halt_in, bus_request} = '0;
      {cii_on, bus_error_in_on, saw_br, perr} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      waits = 2'h0;
      ack_words = 3'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_rmw;
      t_nobr;
      t_burst;
      t_abort;
      t_misc;
      print_verdict;
   end
   initial begin
      #100000;
      n_fail++;
      print_verdict;
   end
endmodule
bind srb_bus_seq srb_monitor u_srb_monitor (.*);
